// ==== rtl/psle_params.svh ====
`ifndef PSLE_PARAMS_SVH
`define PSLE_PARAMS_SVH

// port count and mode select width
`define PSLE_NUM_PORTS      5
`define PSLE_MODE_W         2
// mode select codes
`define PSLE_MODE0_CODE     2'h0
`define PSLE_MODE1_CODE     2'h1
`define PSLE_MODE2_CODE     2'h2
`define PSLE_MODE3_CODE     2'h3
// system clock period in ns
`define PSLE_CLK_PERIOD_NS  10
// blink half period in ms, and its cycle count
`define PSLE_BLINK_HALF_MS  50
`define PSLE_BLINK_HALF_CYC ((`PSLE_BLINK_HALF_MS * 1000000) / `PSLE_CLK_PERIOD_NS)
// activity stretch in ms, and its cycle count
`define PSLE_STRETCH_MS     100
`define PSLE_STRETCH_CYC    ((`PSLE_STRETCH_MS * 1000000) / `PSLE_CLK_PERIOD_NS)
// indicator idle level: lamps are active low, so high is off
`define PSLE_LAMP_OFF       1'h1

`endif

// ==== rtl/psle_pkg.sv ====
package psle_pkg;
   // indicator modes, decoded from the select input
   typedef enum logic [1:0] {
      PSLE_MODE0,
      PSLE_MODE1,
      PSLE_MODE2,
      PSLE_MODE3
   } psle_mode_t;
endpackage : psle_pkg

// ==== rtl/psle_stretch.sv ====
`timescale 1ns/1ns
`include "psle_params.svh"

// holds an event flag for a fixed time after the last event pulse
module psle_stretch #(
   parameter int STRETCH_CYC = `PSLE_STRETCH_CYC
) (
   input  wire logic clk,       // system clock
   input  wire logic resetn,    // synchronous reset, active low
   input  wire logic clk_en,    // freezes state while low
   input  wire logic event_in,  // raw event level
   output logic      held       // stretched event
);
   localparam int CW = $clog2(STRETCH_CYC + 1);

   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;

   // retrigger on every event so a burst of short frames stays lit
   assign count_d = event_in ? CW'(STRETCH_CYC) :
                    (count_q != '0) ? count_q - CW'(1) : count_q;
   assign held    = (count_q != '0);

   // counter
   always_ff @(posedge clk) begin
      if (!resetn) begin
         count_q <= '0;
      end else if (clk_en) begin
         count_q <= count_d;
      end
   end
endmodule : psle_stretch

// ==== rtl/psle_encoder.sv ====
`timescale 1ns/1ns
`include "psle_params.svh"

// Summary of operation
// (R1) select value 0..3 picks mode 0..3; pulled-up default 11 is mode 3
// (R2) indicator groups show status only after reset is released
// (R3) mode 0 link lamp equals mode 2 link lamp
// (R4) mode 1 link lamp: high idle, blinks while receiving
// (R5) mode 2 link lamp: high no 100M link, low idle, blinks on activity
// (R6) mode 3 link lamp: high link down, low up, blinks on activity
// (R7) mode 0 speed group acts as collision lamp, blinks on collision
// (R8) mode 0 only speed bit 0 shows collision of all ports; rest undefined
// (R9) modes 1 and 3 speed lamp: high at 10M, low at 100M
// (R10) mode 2 speed lamp: high half, low full, blinks on collision
// (R11) mode 0 duplex lamp equals mode 2 duplex lamp
// (R12) mode 1 duplex lamp: high link down, low link up, no blink
// (R13) mode 2 duplex lamp: high no 10M link, low idle, blinks on activity
// (R14) mode 3 duplex lamp: high half, low full, blinks on collision
// (R15) blink toggles at fixed rate; events are stretched to stay visible
// (R16) per-port status inputs; all lamp outputs are registered
module psle_encoder
   import psle_pkg::*;
#(
   parameter int NUM_PORTS   = `PSLE_NUM_PORTS,
   parameter int BLINK_CYC   = `PSLE_BLINK_HALF_CYC,
   parameter int STRETCH_CYC = `PSLE_STRETCH_CYC
) (
   input  wire logic                    clk,                    // 100 MHz system clock
   input  wire logic                    resetn,                 // synchronous reset, active low
   input  wire logic                    clk_en,                 // freezes all state while low
   input  wire logic [`PSLE_MODE_W-1:0] indicator_mode_select,  // mode strap
   input  wire logic [NUM_PORTS-1:0]    port_link_up,           // link ok per port
   input  wire logic [NUM_PORTS-1:0]    port_speed_100,         // 1: 100M, 0: 10M
   input  wire logic [NUM_PORTS-1:0]    port_full_duplex,       // 1: full, 0: half
   input  wire logic [NUM_PORTS-1:0]    port_rx_active,         // receiving
   input  wire logic [NUM_PORTS-1:0]    port_tx_active,         // transmitting
   input  wire logic [NUM_PORTS-1:0]    port_collision,         // collision seen
   output logic      [NUM_PORTS-1:0]    link_indicator_out,     // link lamps, active low
   output logic      [NUM_PORTS-1:0]    speed_indicator_out,    // speed lamps, active low
   output logic      [NUM_PORTS-1:0]    duplex_indicator_out    // duplex lamps, active low
);
   localparam int BW = $clog2(BLINK_CYC + 1);

   psle_mode_t          mode;
   logic [BW-1:0]       blink_cnt_q;
   logic [BW-1:0]       blink_cnt_d;
   logic                blink_q;
   logic                blink_d;
   logic [NUM_PORTS-1:0] rx_held;
   logic [NUM_PORTS-1:0] act_held;
   logic [NUM_PORTS-1:0] col_held;
   logic                col_any_held;
   logic [NUM_PORTS-1:0] act_raw;
   logic                col_any_raw;
   logic [NUM_PORTS-1:0] link_d;
   logic [NUM_PORTS-1:0] speed_d;
   logic [NUM_PORTS-1:0] duplex_d;
   logic [NUM_PORTS-1:0] link_q;
   logic [NUM_PORTS-1:0] speed_q;
   logic [NUM_PORTS-1:0] duplex_q;
   logic [NUM_PORTS-1:0] link100_ok;
   logic [NUM_PORTS-1:0] link10_ok;
   logic [NUM_PORTS-1:0] blink_vec;

   // mode decode by binary value of the strap
   assign mode = psle_mode_t'(indicator_mode_select);  // (R1)

   // blink square wave, shared so all lamps but the mode 3 half-duplex duplex lamps (lit while it is high) flash in step
   assign blink_cnt_d = (blink_cnt_q == BW'(BLINK_CYC - 1)) ? '0 : blink_cnt_q + BW'(1);
   assign blink_d     = (blink_cnt_q == BW'(BLINK_CYC - 1)) ? ~blink_q : blink_q;  // (R15)
   assign blink_vec   = {NUM_PORTS{blink_q}};

   // event sources for stretching
   assign act_raw     = port_tx_active | port_rx_active;
   assign col_any_raw = |port_collision;

   // one stretcher per port per event kind; events count whether or not the link is up
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
         psle_stretch #(.STRETCH_CYC(STRETCH_CYC)) u_rx (
            .clk      (clk),
            .resetn   (resetn),
            .clk_en   (clk_en),
            .event_in (port_rx_active[gi]),
            .held     (rx_held[gi])
         );
         psle_stretch #(.STRETCH_CYC(STRETCH_CYC)) u_act (
            .clk      (clk),
            .resetn   (resetn),
            .clk_en   (clk_en),
            .event_in (act_raw[gi]),
            .held     (act_held[gi])
         );
         psle_stretch #(.STRETCH_CYC(STRETCH_CYC)) u_col (
            .clk      (clk),
            .resetn   (resetn),
            .clk_en   (clk_en),
            .event_in (port_collision[gi]),
            .held     (col_held[gi])
         );
      end
   endgenerate

   // collision of any port for the shared lamp
   psle_stretch #(.STRETCH_CYC(STRETCH_CYC)) u_col_any (
      .clk      (clk),
      .resetn   (resetn),
      .clk_en   (clk_en),
      .event_in (col_any_raw),
      .held     (col_any_held)
   );

   // link qualifiers per speed
   assign link100_ok = port_link_up & port_speed_100;
   assign link10_ok  = port_link_up & ~port_speed_100;

   // lamp selection; a blinking lamp alternates off/on with the blink wave
   always_comb begin
      link_d   = {NUM_PORTS{`PSLE_LAMP_OFF}};
      speed_d  = {NUM_PORTS{`PSLE_LAMP_OFF}};
      duplex_d = {NUM_PORTS{`PSLE_LAMP_OFF}};
      unique case (mode)
         PSLE_MODE0: begin
            link_d     = ~link100_ok | (act_held & blink_vec);   // (R3) (R5)
            duplex_d   = ~link10_ok | (act_held & blink_vec);    // (R11) (R13)
            // upper bits have no defined use; they are parked off
            speed_d[0] = ~(col_any_held & ~blink_q);             // (R7) (R8)
         end
         PSLE_MODE1: begin
            link_d   = ~(rx_held & ~blink_vec);                  // (R4)
            speed_d  = ~port_speed_100;                          // (R9)
            duplex_d = ~port_link_up;                            // (R12)
         end
         PSLE_MODE2: begin
            link_d   = ~link100_ok | (act_held & blink_vec);     // (R5)
            speed_d  = ~port_full_duplex | (col_held & blink_vec);  // (R10)
            duplex_d = ~link10_ok | (act_held & blink_vec);      // (R13)
         end
         PSLE_MODE3: begin
            link_d   = ~port_link_up | (act_held & blink_vec);   // (R6)
            speed_d  = ~port_speed_100;                          // (R9)
            // xor so a half-duplex lamp, idle high, still gets a lit phase
            duplex_d = ~port_full_duplex ^ (col_held & blink_vec);  // (R14)
         end
      endcase
      // half-duplex collision lamps, idle high, still need a lit phase to flash
      if (mode == PSLE_MODE2) begin
         speed_d = speed_d & ~(col_held & ~blink_vec & ~port_full_duplex);
      end
   end

   // blink generator state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'h0;
      end else if (clk_en) begin
         blink_cnt_q <= blink_cnt_d;
         blink_q     <= blink_d;
      end
   end

   // registered lamp outputs; all lamps held off while in reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         link_q   <= {NUM_PORTS{`PSLE_LAMP_OFF}};  // (R2)
         speed_q  <= {NUM_PORTS{`PSLE_LAMP_OFF}};
         duplex_q <= {NUM_PORTS{`PSLE_LAMP_OFF}};
      end else if (clk_en) begin
         link_q   <= link_d;                       // (R16)
         speed_q  <= speed_d;
         duplex_q <= duplex_d;
      end
   end

   assign link_indicator_out   = link_q;
   assign speed_indicator_out  = speed_q;
   assign duplex_indicator_out = duplex_q;
endmodule : psle_encoder

// ==== verification/psle_checker.sv ====
`timescale 1ns/1ns
// lamp checks; steady levels only once no event is left in the stretch
module psle_checker #(
   parameter int STRETCH_CYC = 8
) (
   input wire logic       clk,                   // clock
   input wire logic       resetn,                // reset, low
   input wire logic       clk_en,                // enable
   input wire logic [1:0] indicator_mode_select, // mode
   input wire logic [4:0] port_link_up,          // link
   input wire logic [4:0] port_speed_100,        // speed
   input wire logic [4:0] port_full_duplex,      // duplex
   input wire logic [4:0] port_rx_active,        // rx
   input wire logic [4:0] port_tx_active,        // tx
   input wire logic [4:0] port_collision,        // collision
   input wire logic [4:0] link_indicator_out,    // link lamps
   input wire logic [4:0] speed_indicator_out,   // speed lamps
   input wire logic [4:0] duplex_indicator_out   // duplex lamps
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [1:0] up_q;
   int         qc_q;
   logic [1:0] m;
   logic       ok;
   logic       quiet;
   logic [4:0] el;
   logic [4:0] es;
   logic [4:0] ed;
   // outputs follow inputs from the first edge after release; checks start after the second
   always_ff @(posedge clk) up_q <= resetn ? {up_q[0], 1'b1} : 2'h0;
   // saturating count of cycles since the last event
   always_ff @(posedge clk) qc_q <= (!resetn || (|{port_rx_active, port_tx_active, port_collision})) ? 0 :
                                    qc_q + int'(qc_q < 99);
   // steady lamp levels per mode, active low
   assign m = indicator_mode_select;
   assign ok = up_q[1] && clk_en;
   assign quiet = ok && qc_q > STRETCH_CYC + 2;
   assign el = (m == 2'h1) ? 5'h1f : (m == 2'h3) ? ~port_link_up : ~(port_link_up & port_speed_100);
   assign es = (m == 2'h2) ? ~port_full_duplex : ~port_speed_100;
   assign ed = (m == 2'h1) ? ~port_link_up : (m == 2'h3) ? ~port_full_duplex : ~(port_link_up & ~port_speed_100);
   link_steady_a: assert property (quiet |=> link_indicator_out == $past(el))
      else $error("link lamps wrong");
   speed_steady_a: assert property (quiet && m != 2'h0 |=> speed_indicator_out == $past(es))
      else $error("speed lamps wrong");
   duplex_steady_a: assert property (quiet |=> duplex_indicator_out == $past(ed))
      else $error("duplex lamps wrong");
   collision_idle_a: assert property (quiet && m == 2'h0 |=> speed_indicator_out[0])
      else $error("collision lamp lit");
   reset_dark_a: assert property (disable iff (1'b0) !resetn && clk_en |=> &{link_indicator_out,
      speed_indicator_out, duplex_indicator_out}) else $error("lamp lit in reset");
   rx_blink_a: assert property (ok && m == 2'h1 && port_rx_active[0] && port_link_up[0]
      |-> ##[1:12] $changed(link_indicator_out[0])) else $error("rx lamp still");
   col_blink_a: assert property (ok && m == 2'h0 && |port_collision
      |-> ##[1:12] $changed(speed_indicator_out[0])) else $error("collision lamp still");
   act_blink_a: assert property (ok && m == 2'h3 && port_link_up[1] && port_tx_active[1]
      |-> ##[1:12] $changed(link_indicator_out[1])) else $error("activity lamp still");
   dup_col_a: assert property (ok && m == 2'h3 && port_collision[2]
      |-> ##[1:12] $changed(duplex_indicator_out[2])) else $error("duplex lamp still");
   cover property (quiet && m == 2'h0);
   cover property (quiet && m == 2'h2);
   cover property (ok && |port_collision);
endmodule : psle_checker

// ==== verification/psle_lamps.sv ====
`timescale 1ns/1ns
// far side lamp bank; each lamp sinks current, so a low line lights it
module psle_lamps (
   input  wire logic [4:0]  link_indicator_out,   // link lines
   input  wire logic [4:0]  speed_indicator_out,  // speed lines
   input  wire logic [4:0]  duplex_indicator_out, // duplex lines
   output logic      [14:0] lit                   // lit lamps
);
   // a lamp has no memory, it just follows its line
   assign lit = ~{duplex_indicator_out, speed_indicator_out, link_indicator_out};
endmodule : psle_lamps

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
   logic        clk = 0;
   logic        resetn = 0;
   logic        clk_en = 1;
   logic [1:0]  mode = 2'h3;
   logic [4:0]  lnk = 5'h17;
   logic [4:0]  sp = 5'h0d;
   logic [4:0]  fd = 5'h06;
   logic [4:0]  rx = 5'h00;
   logic [4:0]  tx = 5'h00;
   logic [4:0]  col = 5'h00;
   logic [4:0]  lo;
   logic [4:0]  so;
   logic [4:0]  dout;
   logic [14:0] lit;
   int          fail_count = 0;
   int          compares = 0;
   // short blink and stretch keep the run brief
   psle_encoder #(.BLINK_CYC(4), .STRETCH_CYC(8)) dut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
      .indicator_mode_select(mode), .port_link_up(lnk), .port_speed_100(sp), .port_full_duplex(fd),
      .port_rx_active(rx), .port_tx_active(tx), .port_collision(col), .link_indicator_out(lo),
      .speed_indicator_out(so), .duplex_indicator_out(dout));
   psle_lamps lamps (.link_indicator_out(lo), .speed_indicator_out(so), .duplex_indicator_out(dout), .lit(lit));
   initial forever #5 clk = ~clk;
   task automatic chk(string what, logic [4:0] exp, logic [4:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic end_of_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // all lamps dark while reset is held
   task automatic t_reset;
      repeat (16) @(negedge clk);
      chk("reset lamps", 5'h1f, lo & so & dout);
      resetn = 1;
      $display("t_reset done");
   endtask : t_reset
   // each mode with mixed link, speed and duplex per port
   task automatic t_steady;
      logic [4:0] el;
      logic [4:0] es;
      logic [4:0] ed;
      for (int i = 0; i < 4; i++) begin
         mode = 2'(i);
         repeat (3) @(negedge clk);
         el = (i == 1) ? 5'h1f : (i == 3) ? ~lnk : ~(lnk & sp);
         es = (i == 0) ? 5'h01 : (i == 2) ? ~fd : ~sp;
         ed = (i == 1) ? ~lnk : (i == 3) ? ~fd : ~(lnk & ~sp);
         chk("link lamps", el, lo);
         chk("speed lamps", es, (i == 0) ? {4'h0, so[0]} : so);
         chk("duplex lamps", ed, dout);
      end
      $display("t_steady done");
   endtask : t_steady
   // a one-cycle event must still make the chosen lamp flash
   task automatic t_flash(logic [1:0] m, logic [4:0] r, logic [4:0] t, logic [4:0] c, int idx);
      int   n = 0;
      logic prev;
      mode = m;
      repeat (3) @(negedge clk);
      prev = lit[idx];
      rx = r;
      tx = t;
      col = c;
      @(negedge clk);
      rx = 5'h00;
      tx = 5'h00;
      col = 5'h00;
      repeat (14) begin
         @(negedge clk);
         n += int'(lit[idx] != prev);
         prev = lit[idx];
      end
      chk("lamp flash", 5'h01, 5'(n > 0));
      repeat (20) @(negedge clk);
      $display("t_flash done");
   endtask : t_flash
   initial begin
      t_reset();
      t_steady();
      t_flash(2'h1, 5'h01, 5'h00, 5'h00, 0);
      t_flash(2'h0, 5'h00, 5'h00, 5'h08, 5);
      t_flash(2'h3, 5'h00, 5'h02, 5'h00, 1);
      t_flash(2'h3, 5'h00, 5'h00, 5'h04, 12);
      t_flash(2'h2, 5'h00, 5'h01, 5'h00, 0);
      t_flash(2'h2, 5'h00, 5'h00, 5'h02, 6);
      t_flash(2'h2, 5'h10, 5'h00, 5'h00, 14);
      t_flash(2'h3, 5'h00, 5'h00, 5'h01, 10);
      t_flash(2'h2, 5'h00, 5'h00, 5'h01, 5);
      end_of_test();
   end
   // the run needs about 370 cycles; this allows far more
   initial begin
      #20000;
      fail_count++;
      end_of_test();
   end
endmodule : tb_top
bind psle_encoder psle_checker #(.STRETCH_CYC(STRETCH_CYC)) chk_i (.clk(clk), .resetn(resetn), .clk_en(clk_en),
   .indicator_mode_select(indicator_mode_select), .port_link_up(port_link_up), .port_speed_100(port_speed_100),
   .port_full_duplex(port_full_duplex), .port_rx_active(port_rx_active), .port_tx_active(port_tx_active),
   .port_collision(port_collision), .link_indicator_out(link_indicator_out),
   .speed_indicator_out(speed_indicator_out), .duplex_indicator_out(duplex_indicator_out));
